// *** timer_counter_sosc.v ***
// 16-bit timer/counter with clock source select, prescaler, external input
// synchronisation, atomic 16-bit access, secondary oscillator request and power mode tracking
// assumes one clk_sys domain; all pin and strap inputs are synchronous to it
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "timer_counter_defs.vh"

module timer_counter_sosc (
	input wire clk_sys,
	input wire rst_n,
	// register port
	input wire [2:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdData,
	// clock and gate inputs
	input wire externalClockPin,
	input wire secondaryOscClock,
	input wire gateOpen,
	// secondary oscillator requesters, crystal mode and fail-safe status from outside this block
	input wire otherTimerOscRequest,
	input wire rtcSourceConfig,
	input wire crystalModeConfig,
	input wire failSafeSwitched,
	// power management events
	input wire sleepInstruction,
	input wire wakeEvent,
	// crystal pin pair, bit 1 crystal input pin, bit 0 crystal output pin
	input wire [1:0] crystalPinIn,
	input wire [1:0] portDirection,
	input wire [1:0] portOutData,
	output reg [1:0] crystalPinOut,
	output reg [1:0] crystalPinOe_n,
	output reg [1:0] crystalPinRead,
	// status outputs
	output reg secondaryOscEnable,
	output reg secondaryRunMode,
	output reg secondaryIdleMode,
	output reg secondaryClockRunning
);

	// register state
	reg [15:0] countReg;
	reg [15:0] countNext;
	reg [7:0] highBufReg;
	reg [7:0] timerCtlReg;
	reg gateEnReg;
	reg idleOnSleepReg;
	reg [1:0] sysClockSelReg;
	reg warmupReg;
	reg [1:0] modeReg;
	reg [1:0] modeNext;
	reg [1:0] instrDivReg;
	reg extLevelReg;
	reg armedReg;
	reg [7:0] rdNext;

	// decoded control fields
	wire [1:0] clockSource;
	wire [1:0] prescaleSel;
	wire oscEnableBit;
	wire syncBypass;
	wire wideAccess;
	wire timerOn;

	assign clockSource = timerCtlReg[`TC_SRC_HI:`TC_SRC_LO];
	assign prescaleSel = timerCtlReg[`TC_PS_HI:`TC_PS_LO];
	assign oscEnableBit = timerCtlReg[`TC_OSC_EN];
	assign syncBypass = timerCtlReg[`TC_SYNC_BYP];
	assign wideAccess = timerCtlReg[`TC_WIDE];
	assign timerOn = timerCtlReg[`TC_ON];

	// register strobes
	wire wrLow;
	wire wrHigh;
	wire rdLow;

	assign wrLow = regWrite && (regAddr == `OFS_COUNT_LOW);
	assign wrHigh = regWrite && (regAddr == `OFS_COUNT_HIGH);
	assign rdLow = regRead && (regAddr == `OFS_COUNT_LOW);

	// run condition and sleep
	wire inSleep;
	wire runEnable;

	assign inSleep = (modeReg == `MODE_SLEEP);
	// gate enable only matters while the timer is on
	assign runEnable = timerOn && (!gateEnReg || gateOpen);

	// internal source: the system clock ticks every cycle, the instruction
	// clock once every four; both stop in sleep with the core clock
	wire instrTick;
	wire internalTick;
	wire externalSel;

	assign instrTick = (instrDivReg == `INSTR_DIV_LAST);
	assign externalSel = (clockSource == `SRC_EXTERNAL);
	// code 11 is reserved and never counts
	assign internalTick = !inSleep && ((clockSource == `SRC_SYSTEM) ||
		((clockSource == `SRC_INSTR) && instrTick));

	// free-running from reset, so the instruction phase is not tied to the timer enable
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			instrDivReg <= 2'h0;
		end else begin
			instrDivReg <= instrDivReg + 2'h1;
		end
	end

	// external source: pin or secondary oscillator, by the enable bit
	wire extRaw;
	wire extRise;

	assign extRaw = oscEnableBit ? secondaryOscClock : externalClockPin;
	// a rising edge only counts once a low level has been seen since arming
	assign extRise = extRaw && !extLevelReg && armedReg;
	// arming on a sampled low level rather than a falling edge also covers a pin
	// that was already low when the timer was switched on

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			extLevelReg <= 1'b0;
			armedReg <= 1'b0;
		end else begin
			extLevelReg <= extRaw;
			if (!timerOn || wrLow || wrHigh) begin
				armedReg <= 1'b0;
			end else if (!extRaw) begin
				armedReg <= 1'b1;
			end
		end
	end

	// prescaler sits ahead of the synchroniser
	wire prescaleIn;
	wire prescaleTick;
	wire prescaleToggle;
	wire syncTick;

	wire syncedPath;
	wire extTick;

	// the synchronised path must sleep with the core: a prescaler still
	// toggling in sleep would hand the synchroniser a stale edge on wake
	assign syncedPath = externalSel && !syncBypass;
	assign extTick = extRise && !(syncedPath && inSleep);
	assign prescaleIn = runEnable && (externalSel ? extTick : internalTick);

	count_prescaler prescaler (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tickIn(prescaleIn),
		.clear(wrLow),
		.ratio(prescaleSel),
		.tickOut(prescaleTick),
		.toggleOut(prescaleToggle)
	);

	edge_sync extSync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.toggleIn(prescaleToggle),
		.hold(inSleep),
		.pulseOut(syncTick)
	);

	// the synchronised path costs three cycles of latency; the bypass path
	// keeps counting in sleep because it needs no core clock
	wire incrTick;

	// a tick still in flight when the timer stops is dropped, so a stop is immediate
	assign incrTick = runEnable && (syncedPath ? syncTick : prescaleTick);

	// counter with software loads; a write beats an increment in the same cycle
	always @* begin
		countNext = countReg;
		if (wrLow) begin
			countNext[7:0] = regWrData;
			if (wideAccess) begin
				countNext[15:8] = highBufReg;
			end
		end else if (wrHigh && !wideAccess) begin
			countNext[15:8] = regWrData;
		end else if (incrTick) begin
			countNext = countReg + 16'h0001;
		end
	end

	// register writes
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			countReg <= `RST_COUNT;
			highBufReg <= `RST_BYTE;
			timerCtlReg <= `RST_BYTE;
			gateEnReg <= 1'b0;
			idleOnSleepReg <= 1'b0;
			sysClockSelReg <= `RST_SCS;
			warmupReg <= 1'b0;
		end else begin
			countReg <= countNext;
			if (wrHigh && wideAccess) begin
				highBufReg <= regWrData;
			end else if (rdLow && wideAccess) begin
				highBufReg <= countReg[15:8];
			end
			if (regWrite) begin
				if (regAddr == `OFS_TIMER_CTL) begin
					timerCtlReg <= regWrData;
				end else if (regAddr == `OFS_GATE_CTL) begin
					gateEnReg <= regWrData[`GC_GATE_EN];
				end else if (regAddr == `OFS_OSC_CTL) begin
					idleOnSleepReg <= regWrData[`OC_IDLE];
					sysClockSelReg <= regWrData[`OC_SCS_HI:`OC_SCS_LO];
				end else if (regAddr == `OFS_OSC_CTL_TWO) begin
					warmupReg <= regWrData[`OC2_WARMUP];
				end
			end
		end
	end

	// read mux; data stand only in the cycle after the strobe
	// reserved bits and the unmapped offsets read as zero
	always @* begin
		rdNext = 8'h00;
		if (regAddr == `OFS_COUNT_LOW) begin
			rdNext = countReg[7:0];
		end else if (regAddr == `OFS_COUNT_HIGH) begin
			rdNext = wideAccess ? highBufReg : countReg[15:8];
		end else if (regAddr == `OFS_TIMER_CTL) begin
			rdNext = timerCtlReg;
		end else if (regAddr == `OFS_GATE_CTL) begin
			rdNext[`GC_GATE_EN] = gateEnReg;
		end else if (regAddr == `OFS_OSC_CTL) begin
			rdNext[`OC_IDLE] = idleOnSleepReg;
			rdNext[`OC_SCS_HI:`OC_SCS_LO] = sysClockSelReg;
		end else if (regAddr == `OFS_OSC_CTL_TWO) begin
			rdNext[`OC2_RUNNING] = secondaryClockRunning;
			rdNext[`OC2_WARMUP] = warmupReg;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= `RST_BYTE;
		end else begin
			regRdData <= regRead ? rdNext : 8'h00;
		end
	end

	// power mode tracking
	always @* begin
		modeNext = modeReg;
		case (modeReg)
			`MODE_PRIMARY: begin
				if (sysClockSelReg == `SRC_SYSTEM) begin
					modeNext = `MODE_SECONDARY_RUN_MODE;
				end else if (sleepInstruction) begin
					modeNext = `MODE_SLEEP;
				end
			end
			`MODE_SECONDARY_RUN_MODE: begin
				if (sleepInstruction) begin
					modeNext = idleOnSleepReg ? `MODE_SLEEP : `MODE_SECONDARY_IDLE_MODE;
				end else if (sysClockSelReg != `SRC_SYSTEM) begin
					modeNext = `MODE_PRIMARY;
				end
			end
			`MODE_SECONDARY_IDLE_MODE: begin
				if (wakeEvent) begin
					modeNext = `MODE_SECONDARY_RUN_MODE;
				end
			end
			default: begin
				if (wakeEvent) begin
					modeNext = `MODE_PRIMARY;
				end
			end
		endcase
	end

	// any single requester is enough to keep the oscillator running
	wire oscRequestAny;
	wire runningNext;

	assign oscRequestAny = oscEnableBit ||
		otherTimerOscRequest ||
		rtcSourceConfig ||
		(sysClockSelReg == `SRC_SYSTEM) ||
		warmupReg;
	// the fail-safe monitor may have moved the core off the oscillator
	assign runningNext = ((modeNext == `MODE_SECONDARY_RUN_MODE) ||
		(modeNext == `MODE_SECONDARY_IDLE_MODE)) && !failSafeSwitched;

	// oscillator request and status; no mode term gates the enable, so the
	// oscillator survives every power-managed mode once asked for
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			modeReg <= `RST_MODE;
			secondaryOscEnable <= 1'b0;
			secondaryRunMode <= 1'b0;
			secondaryIdleMode <= 1'b0;
			secondaryClockRunning <= 1'b0;
		end else begin
			modeReg <= modeNext;
			secondaryOscEnable <= oscRequestAny;
			secondaryRunMode <= (modeNext == `MODE_SECONDARY_RUN_MODE);
			secondaryIdleMode <= (modeNext == `MODE_SECONDARY_IDLE_MODE);
			secondaryClockRunning <= runningNext;
		end
	end

	// crystal pin pair: crystal mode overrides direction and masks reads
	wire [1:0] pinOeNext;
	wire [1:0] pinReadNext;

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : pinGen
			assign pinOeNext[i] = crystalModeConfig || portDirection[i];
			// the pin swings with the crystal, so a digital read must not see it
			assign pinReadNext[i] = crystalModeConfig ? 1'b0 : crystalPinIn[i];
		end
	endgenerate

	// one process drives all three output vectors, a single driver on each
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crystalPinOut <= 2'b00;
			crystalPinOe_n <= 2'b11;
			crystalPinRead <= 2'b00;
		end else begin
			crystalPinOut <= portOutData;
			crystalPinOe_n <= pinOeNext;
			crystalPinRead <= pinReadNext;
		end
	end

endmodule
`default_nettype wire

// *** timer_counter_defs.vh ***
// constants for the 16-bit timer/counter with its secondary oscillator request logic
// assumes byte-wide registers on a plain strobe port, one system clock, no package
//
// What this block does
// - sixteen-bit up counter, software sees it as high and low count bytes
// - internal source counts once per instruction cycle (00) or every system clock (01) before the prescaler
// - counting needs the timer on bit, plus the gate input open when gate enable is set
// - crystal mode forces both crystal pins to inputs, direction ignored, reads zero
// - source 01 system clock, 00 instruction clock, 10 pin or oscillator by enable
// - external source increments on each rising edge of the external input
// - external source is either synchronised to system clock or counted asynchronously
// - counter mode needs a sampled low level before first rising edge after enable/write/disable
// - synchroniser stops in sleep, only asynchronous external counting continues
// - internal source advances on multiples of oscillator set by prescaler ratio
// - wide mode maps high address to buffer, low read copies live high byte
// - wide mode high write fills buffer, low write loads both bytes together
// - wide mode gives no direct path to the live high byte
// - low byte write clears prescaler, high byte write leaves it alone
// - oscillator runs when any timer, rtc config, clock select or warm-up asks
// - once enabled the oscillator keeps running through every power-managed mode
// - clock select 01 enters secondary-run mode, core and peripherals on oscillator
// - secondary-run with idle bit clear and a sleep instruction enters secondary-idle
// - read-only running flag shows oscillator supplies system clock, fail-safe included
// - prescale field divides by 1, 2, 4 or 8 for codes 00 to 11
// - sync select bit set bypasses synchroniser, clear synchronises, ignored when internal
// - count runs 0000h to FFFFh then wraps to 0000h
`ifndef TIMER_COUNTER_DEFS_VH
`define TIMER_COUNTER_DEFS_VH

// register offsets
`define OFS_COUNT_LOW 3'h0
`define OFS_COUNT_HIGH 3'h1
`define OFS_TIMER_CTL 3'h2
`define OFS_GATE_CTL 3'h3
`define OFS_OSC_CTL 3'h4
`define OFS_OSC_CTL_TWO 3'h5

// timer_control_reg fields
`define TC_SRC_HI 7
`define TC_SRC_LO 6
`define TC_PS_HI 5
`define TC_PS_LO 4
`define TC_OSC_EN 3
`define TC_SYNC_BYP 2
`define TC_WIDE 1
`define TC_ON 0

// gate_control_reg, oscillator_control_reg and oscillator_control_reg_two fields
`define GC_GATE_EN 7
`define OC_IDLE 7
`define OC_SCS_HI 1
`define OC_SCS_LO 0
`define OC2_RUNNING 6
`define OC2_WARMUP 3

// reset values
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000
`define RST_SCS 2'h0
`define RST_MODE 2'h0

// clock source codes
`define SRC_INSTR 2'h0
`define SRC_SYSTEM 2'h1
`define SRC_EXTERNAL 2'h2

// power mode codes
`define MODE_PRIMARY 2'h0
`define MODE_SECONDARY_RUN_MODE 2'h1
`define MODE_SECONDARY_IDLE_MODE 2'h2
`define MODE_SLEEP 2'h3

// system clock cycles per instruction cycle, minus one
`define INSTR_DIV_LAST 2'h3

`endif

// *** count_prescaler.v ***
// prescaler for the count clock: divides incoming ticks by 1, 2, 4 or 8
// assumes tick is a one-cycle pulse in the clk_sys domain
`timescale 1ns/10ps
`default_nettype none
`include "timer_counter_defs.vh"

module count_prescaler (
	input wire clk_sys,
	input wire rst_n,
	input wire tickIn,
	input wire clear,
	input wire [1:0] ratio,
	output reg tickOut,
	output reg toggleOut
);

	reg [2:0] countReg;
	wire [2:0] lastCount;
	wire wrap;

	assign lastCount = (3'h1 << ratio) - 3'h1;
	assign wrap = tickIn && (countReg >= lastCount);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			countReg <= 3'h0;
			tickOut <= 1'b0;
			toggleOut <= 1'b0;
		end else begin
			tickOut <= wrap;
			// clear wins over a same-cycle tick for countReg and toggleOut, not for tickOut
			if (clear) begin
				countReg <= 3'h0;
			end else if (wrap) begin
				countReg <= 3'h0;
				toggleOut <= ~toggleOut;
			end else if (tickIn) begin
				countReg <= countReg + 3'h1;
			end
		end
	end

endmodule
`default_nettype wire

// *** edge_sync.v ***
// two-stage synchroniser for the prescaled external toggle, plus change detect
// assumes the toggle flips once per prescaled edge; hold freezes it during sleep
`timescale 1ns/10ps
`default_nettype none

module edge_sync (
	input wire clk_sys,
	input wire rst_n,
	input wire toggleIn,
	input wire hold,
	output reg pulseOut
);

	reg stageOne;
	reg stageTwo;
	reg stageLast;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stageOne <= 1'b0;
			stageTwo <= 1'b0;
			stageLast <= 1'b0;
			pulseOut <= 1'b0;
		end else if (hold) begin
			pulseOut <= 1'b0;
		end else begin
			stageOne <= toggleIn;
			stageTwo <= stageOne;
			stageLast <= stageTwo;
			pulseOut <= stageTwo ^ stageLast;
		end
	end

endmodule
`default_nettype wire

// *** timer_counter_sosc_checker.sv ***
// assertions on the ports of the timer/counter with secondary oscillator logic
// assumes one clk_sys domain and bind onto timer_counter_sosc
`timescale 1ns/10ps
`default_nettype none
module timer_counter_sosc_checker (
	input wire clk_sys,
	input wire rst_n,
	input wire [2:0] regAddr,
	input wire regRead,
	input wire [7:0] regRdData,
	input wire otherTimerOscRequest,
	input wire rtcSourceConfig,
	input wire crystalModeConfig,
	input wire failSafeSwitched,
	input wire sleepInstruction,
	input wire [1:0] crystalPinOe_n,
	input wire [1:0] crystalPinRead,
	input wire secondaryOscEnable,
	input wire secondaryRunMode,
	input wire secondaryIdleMode,
	input wire secondaryClockRunning
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_RD_IDLE: assert property (!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data outside its slot");
	AST_UNMAPPED: assert property (regRead && regAddr[2:1] == 2'b11 |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	// the past of reset keeps the first edge after release quiet
	AST_OSC_REQ: assert property ($past(rst_n) && ($past(otherTimerOscRequest)
		|| $past(rtcSourceConfig)) |-> secondaryOscEnable)
		else $error("oscillator request lost");
	AST_PIN_OE: assert property ($past(rst_n) && $past(crystalModeConfig) |-> crystalPinOe_n == 2'b11)
		else $error("crystal pin driven");
	AST_PIN_READ: assert property ($past(rst_n) && $past(crystalModeConfig) |-> crystalPinRead == 2'b00)
		else $error("crystal pin read not zero");
	AST_RUN_FLAG: assert property (secondaryClockRunning |->
		(secondaryRunMode || secondaryIdleMode) && !$past(failSafeSwitched))
		else $error("running flag without oscillator clock");
	AST_MODE_EXCL: assert property (!(secondaryRunMode && secondaryIdleMode))
		else $error("two power modes at once");
	AST_IDLE_ENTRY: assert property ($rose(secondaryIdleMode) |->
		$past(sleepInstruction) && $past(secondaryRunMode))
		else $error("idle entered without sleep from run");
	AST_IDLE_OSC: assert property (secondaryIdleMode |-> secondaryOscEnable)
		else $error("oscillator stopped in idle");
	cover property ($rose(secondaryIdleMode));
	cover property ($fell(secondaryClockRunning) && $past(failSafeSwitched));
	cover property ($past(crystalModeConfig) && crystalPinOe_n == 2'b11);
endmodule
bind timer_counter_sosc timer_counter_sosc_checker timer_counter_sosc_checker_i (
	.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regRead(regRead),
	.regRdData(regRdData), .otherTimerOscRequest(otherTimerOscRequest),
	.rtcSourceConfig(rtcSourceConfig), .crystalModeConfig(crystalModeConfig),
	.failSafeSwitched(failSafeSwitched), .sleepInstruction(sleepInstruction),
	.crystalPinOe_n(crystalPinOe_n), .crystalPinRead(crystalPinRead),
	.secondaryOscEnable(secondaryOscEnable), .secondaryRunMode(secondaryRunMode),
	.secondaryIdleMode(secondaryIdleMode), .secondaryClockRunning(secondaryClockRunning));
`default_nettype wire

// *** ext_clock_source.sv ***
// far side model: external count pin and secondary crystal oscillator
// assumes clk_sys from the bench; both lines stand still between bursts
`timescale 1ns/10ps
`default_nettype none
module ext_clock_source (
	input wire clk_sys,
	output logic externalClockPin,
	output logic secondaryOscClock,
	output logic [1:0] crystalPinIn
);
	initial begin
		externalClockPin = 1'b0;
		secondaryOscClock = 1'b0;
	end
	// crystal pair swings in opposition while the oscillator runs
	assign crystalPinIn = {secondaryOscClock, ~secondaryOscClock};
	task automatic park(input logic v);
		@(posedge clk_sys);
		externalClockPin <= v;
	endtask
	// slow edges, six system clocks per half period, so the synchroniser sees each one
	task automatic burst(input int n, input logic osc);
		for (int i = 0; i < 2 * n; i++) begin
			repeat (6) @(posedge clk_sys);
			if (osc)
				secondaryOscClock <= ~secondaryOscClock;
			else
				externalClockPin <= ~externalClockPin;
		end
	endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the timer/counter with secondary oscillator logic
// assumes design, checker and far side model compiled first; clk_sys at 125 MHz
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	logic clk_sys, rst_n, regWrite, regRead, gateOpen, otherTimerOscRequest, rtcSourceConfig;
	logic crystalModeConfig, failSafeSwitched, sleepInstruction, wakeEvent, externalClockPin;
	logic secondaryOscClock, secondaryOscEnable, secondaryRunMode, secondaryIdleMode;
	logic secondaryClockRunning;
	logic [2:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic [1:0] portDirection, portOutData, crystalPinIn, crystalPinOut, crystalPinOe_n;
	logic [1:0] crystalPinRead;
	logic [31:0] seed = 32'h3ccf_9938;
	logic [15:0] start, e;
	int n, fail_count = 0, tests_run = 0;
	wire [3:0] pm = {secondaryRunMode, secondaryIdleMode, secondaryClockRunning, secondaryOscEnable};
	timer_counter_sosc timer_counter_sosc_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .externalClockPin(externalClockPin),
		.secondaryOscClock(secondaryOscClock), .gateOpen(gateOpen),
		.otherTimerOscRequest(otherTimerOscRequest), .rtcSourceConfig(rtcSourceConfig),
		.crystalModeConfig(crystalModeConfig), .failSafeSwitched(failSafeSwitched),
		.sleepInstruction(sleepInstruction), .wakeEvent(wakeEvent),
		.crystalPinIn(crystalPinIn), .portDirection(portDirection), .portOutData(portOutData),
		.crystalPinOut(crystalPinOut), .crystalPinOe_n(crystalPinOe_n),
		.crystalPinRead(crystalPinRead), .secondaryOscEnable(secondaryOscEnable),
		.secondaryRunMode(secondaryRunMode), .secondaryIdleMode(secondaryIdleMode),
		.secondaryClockRunning(secondaryClockRunning));
	ext_clock_source ext_clock_source_i (.clk_sys(clk_sys), .externalClockPin(externalClockPin),
		.secondaryOscClock(secondaryOscClock), .crystalPinIn(crystalPinIn));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] exp_count(input logic [15:0] s, input int t, input int ps);
		return s + 16'(t >> ps);
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] x);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		`CHK(regRdData, x)
		@(posedge clk_sys);
	endtask
	// t ticks are counted: the stop write drops the tick still in flight, so the
	// enable window is one cycle longer than t
	task automatic run(input logic [7:0] ctl, input int t);
		wr(3'h2, ctl);
		repeat (t - 1) @(posedge clk_sys);
		wr(3'h2, 8'h00);
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic power_event(input logic wake);
		wakeEvent <= wake;
		sleepInstruction <= !wake;
		@(posedge clk_sys);
		{wakeEvent, sleepInstruction} <= 2'b00;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (30000) @(posedge clk_sys);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		{regWrite, regRead, gateOpen, otherTimerOscRequest, rtcSourceConfig} = '0;
		{crystalModeConfig, failSafeSwitched, sleepInstruction, wakeEvent} = '0;
		{regAddr, regWrData, portDirection, portOutData} = '0;
		rst_n = 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		for (int a = 0; a < 8; a++)
			rd(3'(a), 8'h00);
		for (int k = 0; k < 8; k++) begin
			seed = lfsr_next(seed);
			start = (k == 0) ? 16'hfffe : seed[15:0];
			wr(3'h1, start[15:8]);
			wr(3'h0, start[7:0]);
			run({1'b0, k[2], k[1:0], 4'h1}, 64);
			e = exp_count(start, k[2] ? 64 : 16, k[1:0]);
			rd(3'h0, e[7:0]);
			rd(3'h1, e[15:8]);
		end
		wr(3'h3, 8'h80);
		run(8'h41, 16);
		rd(3'h0, e[7:0]);
		gateOpen <= 1'b1;
		run(8'h41, 16);
		e = e + 16'h0010;
		rd(3'h0, e[7:0]);
		wr(3'h2, 8'h02);
		wr(3'h1, 8'hab);
		wr(3'h0, 8'hcd);
		wr(3'h2, 8'h00);
		rd(3'h1, 8'hab);
		wr(3'h2, 8'h02);
		wr(3'h1, 8'h55);
		rd(3'h1, 8'h55);
		wr(3'h2, 8'h00);
		rd(3'h1, 8'hab);
		wr(3'h2, 8'h02);
		rd(3'h0, 8'hcd);
		rd(3'h1, 8'hab);
		for (int s = 0; s < 3; s++) begin
			seed = lfsr_next(seed);
			n = 1 + seed[2:0];
			ext_clock_source_i.park(1'b1);
			wr(3'h1, 8'h00);
			wr(3'h0, 8'h00);
			wr(3'h2, {4'h8, s[1], s[0] | s[1], 2'b01});
			repeat (20) @(posedge clk_sys);
			rd(3'h0, 8'h00);
			ext_clock_source_i.burst(n, s[1]);
			ext_clock_source_i.park(1'b0);
			repeat (10) @(posedge clk_sys);
			rd(3'h0, 8'(n));
			wr(3'h2, 8'h00);
		end
		for (int r = 0; r < 4; r++) begin
			otherTimerOscRequest <= (r == 0);
			rtcSourceConfig <= (r == 1);
			wr(3'h2, (r == 2) ? 8'h08 : 8'h00);
			wr(3'h5, (r == 3) ? 8'h08 : 8'h00);
			@(posedge clk_sys);
			`CHK(secondaryOscEnable, 1'b1)
		end
		{otherTimerOscRequest, rtcSourceConfig} <= 2'b00;
		wr(3'h5, 8'h00);
		@(posedge clk_sys);
		`CHK(secondaryOscEnable, 1'b0)
		wr(3'h4, 8'h01);
		@(posedge clk_sys);
		`CHK(pm, 4'b1011)
		rd(3'h5, 8'h40);
		failSafeSwitched <= 1'b1;
		repeat (3) @(posedge clk_sys);
		`CHK(secondaryClockRunning, 1'b0)
		failSafeSwitched <= 1'b0;
		power_event(1'b0);
		`CHK(pm, 4'b0111)
		power_event(1'b1);
		`CHK(pm, 4'b1011)
		wr(3'h4, 8'h81);
		power_event(1'b0);
		`CHK(pm, 4'b0001)
		wr(3'h4, 8'h00);
		for (int c = 0; c < 2; c++) begin
			seed = lfsr_next(seed);
			crystalModeConfig <= c[0];
			portDirection <= seed[1:0];
			portOutData <= seed[3:2];
			repeat (3) @(posedge clk_sys);
			`CHK(crystalPinOe_n, c[0] ? 2'b11 : seed[1:0])
			`CHK(crystalPinRead, c[0] ? 2'b00 : crystalPinIn)
			`CHK(crystalPinOut, seed[3:2])
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
